/* core/rsa_pkg.sv */
// Constants for the serial access port and clock-rate trim of the RTC.
// Assumes a single 10 MHz system clock; all pins are synchronised inside the core.
package rsa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and correction period timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned COARSE_PERIOD_S = 20;
  localparam int unsigned FINE_PERIOD_S   = 60;
  localparam int unsigned COARSE_CYCLES   = COARSE_PERIOD_S * CLK_HZ;
  localparam int unsigned FINE_CYCLES     = FINE_PERIOD_S * CLK_HZ;
  localparam int unsigned PERIOD_W        = 30;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte layout: fixed code, group, select, read/write
  localparam logic [3:0] CMD_CODE     = 4'h6;
  localparam logic [1:0] GRP_STATUS   = 2'h0;
  localparam logic [1:0] GRP_REALTIME = 2'h1;
  localparam logic [1:0] GRP_ALARM    = 2'h2;
  localparam logic [1:0] GRP_AUX      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Second status register fields
  localparam int unsigned S2_ALARM1_BIT = 1;
  localparam int unsigned S2_A2EN_BIT   = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Byte lengths, trim layout and reset values
  localparam logic [1:0] LEN_SHORT = 2'h1;
  localparam logic [1:0] LEN_ALARM = 2'h3;
  localparam logic [1:0] LEN_NONE  = 2'h0;
  localparam int unsigned ALARM_BYTES = 6;
  localparam int unsigned TRIM_FINE_BIT = 0;
  localparam logic signed [18:0] STEP_PPB_COARSE = 19'sh00bec;
  localparam logic signed [18:0] STEP_PPB_FINE   = 19'sh003f9;
  localparam logic [7:0] STATUS1_RESET = 8'h00;
  localparam logic [7:0] STATUS2_RESET = 8'h00;
  localparam logic [7:0] ALARM_RESET   = 8'h00;
  localparam logic [7:0] TRIM_RESET    = 8'h00;
  localparam logic [7:0] FREE_RESET    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_RD   = 4'b0100,
    ST_WR   = 4'b1000
  } rsa_state_t;

endpackage

/* core/rsa_core.sv */
// Serial register port and clock-rate trim of a low-power RTC.
// Assumes the host drives chip_select and serial_clock; the data line is resolved outside.
// How it works
// - Host changes data on falling clock edges; device samples on rising edges.
// - Eighth sampled bit high enters the read state for the addressed register.
// - In read, register bits are driven out on each following falling edge.
// - Eighth sampled bit low enters write; following bits go into chosen register.
// - Fewer than eight clocks after select: wait, no read or write.
// - Status command select bit picks first or second status register.
// - Alarm command select bit picks first or second alarm register.
// - First alarm is three bytes in alarm mode, else one free byte.
// - Second alarm is three bytes while its enable bit is set.
// - Trim bit0 low: step 3.052 ppm, range +192.3 to -195.3 ppm.
// - Trim bit0 high: step 1.017 ppm, range +64.1 to -65.1 ppm.
// - Trim bits 7..1 are signed count, bit1 MSB; zero means no correction.
// - Trim applied every 20 s with bit0 low, every 60 s high.
`timescale 1ns/10ps
module rsa_core #(
  parameter int unsigned COARSE_CYCLES = rsa_pkg::COARSE_CYCLES,
  parameter int unsigned FINE_CYCLES   = rsa_pkg::FINE_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               chip_select,
  input  wire logic               serial_clock,
  input  wire logic               serial_data_in,
  output logic                    serial_data_out,
  output logic                    serial_data_oe,
  output logic                    alarm1_mode,
  output logic                    second_alarm_enable,
  output logic                    trim_apply,
  output logic signed [18:0]      trim_ppb
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Byte length of the addressed register
  function automatic logic [1:0] byte_len(input logic [2:0] cmd, input logic a1, input logic a2);
    byte_len = rsa_pkg::LEN_SHORT;
    if (cmd[2:1] == rsa_pkg::GRP_REALTIME) begin
      byte_len = rsa_pkg::LEN_NONE;
    end else if (cmd[2:1] == rsa_pkg::GRP_ALARM) begin
      if ((!cmd[0] && a1) || (cmd[0] && a2)) begin
        byte_len = rsa_pkg::LEN_ALARM;
      end
    end
  endfunction
  // Alarm storage index from select bit and byte number
  function automatic logic [2:0] alarm_index(input logic sel, input logic [1:0] idx);
    alarm_index = sel ? 3'(3'h3 + {1'b0, idx}) : {1'b0, idx};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                  cs_q1, cs_q2, cs_q3;
  logic                  sck_q1, sck_q2, sck_q3;
  logic                  sdi_q1, sdi_q2;
  logic                  sck_rise, sck_fall, cs_start;
  rsa_pkg::rsa_state_t   state;
  logic [2:0]            bit_cnt;
  logic [1:0]            byte_cnt;
  logic [6:0]            cmd_sh;
  logic [7:0]            next_cmd;
  logic [2:0]            cmd_reg;
  logic [7:0]            shift;
  logic [7:0]            next_wr;
  logic [1:0]            cur_len;
  logic                  in_range;
  logic                  wr_commit;
  logic [2:0]            rd_cmd;
  logic [1:0]            rd_idx;
  logic [7:0]            rd_data;
  logic [7:0]            status1, status2;
  logic [7:0]            alarm [0:rsa_pkg::ALARM_BYTES-1];
  logic [7:0]            trim;
  logic [7:0]            free_reg;
  logic signed [6:0]     trim_step;
  logic [rsa_pkg::PERIOD_W-1:0] per_cnt, per_last;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  always_ff @(posedge clock) begin
    if (srst) begin
      cs_q1  <= 1'b0;
      cs_q2  <= 1'b0;
      cs_q3  <= 1'b0;
      sck_q1 <= 1'b1; // Idle level, no false edge
      sck_q2 <= 1'b1;
      sck_q3 <= 1'b1;
      sdi_q1 <= 1'b0;
      sdi_q2 <= 1'b0;
    end else begin
      cs_q1  <= chip_select;
      cs_q2  <= cs_q1;
      cs_q3  <= cs_q2;
      sck_q1 <= serial_clock;
      sck_q2 <= sck_q1;
      sck_q3 <= sck_q2;
      sdi_q1 <= serial_data_in;
      sdi_q2 <= sdi_q1;
    end
  end
  // Edges of the synchronised pins
  assign sck_rise  = sck_q2 & ~sck_q3;
  assign sck_fall  = ~sck_q2 & sck_q3;
  assign cs_start  = cs_q2 & ~cs_q3;
  assign next_cmd  = {cmd_sh, sdi_q2};
  assign next_wr   = {sdi_q2, shift[7:1]};
  assign cur_len   = byte_len(cmd_reg, alarm1_mode, second_alarm_enable);
  assign in_range  = byte_cnt < cur_len;
  assign wr_commit = (state == rsa_pkg::ST_WR) && sck_rise && (bit_cnt == 3'h7) && in_range;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= rsa_pkg::ST_IDLE;
    end else if (!cs_q2) begin
      state <= rsa_pkg::ST_IDLE;
    end else begin
      unique case (state)
        rsa_pkg::ST_IDLE: begin
          if (cs_start) begin
            state <= rsa_pkg::ST_CMD;
          end
        end
        rsa_pkg::ST_CMD: begin
          if (sck_rise && bit_cnt == 3'h7) begin
            if (next_cmd[7:4] != rsa_pkg::CMD_CODE) begin
              state <= rsa_pkg::ST_IDLE;
            end else if (next_cmd[0]) begin
              state <= rsa_pkg::ST_RD;
            end else begin
              state <= rsa_pkg::ST_WR;
            end
          end
        end
        rsa_pkg::ST_RD, rsa_pkg::ST_WR: state <= state;
        default: state <= rsa_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit and byte counting, command capture, data shifting
  always_ff @(posedge clock) begin
    if (srst || !cs_q2 || state == rsa_pkg::ST_IDLE) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
      cmd_sh   <= 7'h00;
      cmd_reg  <= 3'h0;
      shift    <= 8'h00;
    end else if (state == rsa_pkg::ST_CMD) begin
      if (sck_rise) begin
        cmd_sh  <= next_cmd[6:0];
        bit_cnt <= 3'(bit_cnt + 3'h1);
        if (bit_cnt == 3'h7) begin
          cmd_reg <= next_cmd[3:1];
          shift   <= rd_data;
        end
      end
    end else if (state == rsa_pkg::ST_RD) begin
      if (sck_fall && in_range) begin
        bit_cnt <= 3'(bit_cnt + 3'h1);
        if (bit_cnt == 3'h7) begin
          byte_cnt <= 2'(byte_cnt + 2'h1);
          shift    <= rd_data;
        end else begin
          shift <= {1'b0, shift[7:1]};
        end
      end
    end else if (sck_rise && in_range) begin
      shift   <= next_wr;
      bit_cnt <= 3'(bit_cnt + 3'h1);
      if (bit_cnt == 3'h7) begin
        byte_cnt <= 2'(byte_cnt + 2'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  assign rd_cmd = (state == rsa_pkg::ST_CMD) ? next_cmd[3:1] : cmd_reg;
  assign rd_idx = (state == rsa_pkg::ST_CMD) ? 2'h0 : 2'(byte_cnt + 2'h1);
  // Byte that goes out next
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_cmd[2:1])
      rsa_pkg::GRP_STATUS: rd_data = rd_cmd[0] ? status2 : status1;
      rsa_pkg::GRP_ALARM: begin
        if (rd_idx != 2'h3) begin
          rd_data = alarm[alarm_index(rd_cmd[0], rd_idx)];
        end
      end
      rsa_pkg::GRP_AUX: rd_data = rd_cmd[0] ? free_reg : trim;
      rsa_pkg::GRP_REALTIME: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive
  always_ff @(posedge clock) begin
    if (srst || !cs_q2 || state != rsa_pkg::ST_RD) begin
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end else if (sck_fall) begin
      serial_data_out <= shift[0];
      serial_data_oe  <= in_range;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge clock) begin
    if (srst) begin
      status1  <= rsa_pkg::STATUS1_RESET;
      status2  <= rsa_pkg::STATUS2_RESET;
      trim     <= rsa_pkg::TRIM_RESET;
      free_reg <= rsa_pkg::FREE_RESET;
      for (int i = 0; i < rsa_pkg::ALARM_BYTES; i++) begin
        alarm[i] <= rsa_pkg::ALARM_RESET;
      end
    end else if (wr_commit) begin
      unique case (cmd_reg[2:1])
        rsa_pkg::GRP_STATUS: begin
          if (cmd_reg[0]) begin
            status2 <= next_wr;
          end else begin
            status1 <= next_wr;
          end
        end
        rsa_pkg::GRP_ALARM: begin
          alarm[alarm_index(cmd_reg[0], byte_cnt)] <= next_wr;
        end
        rsa_pkg::GRP_AUX: begin
          if (cmd_reg[0]) begin
            free_reg <= next_wr;
          end else begin
            trim <= next_wr;
          end
        end
        rsa_pkg::GRP_REALTIME: free_reg <= free_reg;
      endcase
    end
  end
  // Alarm modes from the second status register
  assign alarm1_mode         = status2[rsa_pkg::S2_ALARM1_BIT];
  assign second_alarm_enable = status2[rsa_pkg::S2_A2EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Trim step count, bit1 most significant
  always_comb begin
    trim_step = 7'sh00;
    for (int i = 0; i < 7; i++) begin
      trim_step[6-i] = trim[1+i];
    end
  end
  // Correction interval
  assign per_last = trim[rsa_pkg::TRIM_FINE_BIT] ? rsa_pkg::PERIOD_W'(FINE_CYCLES - 1)
                                                 : rsa_pkg::PERIOD_W'(COARSE_CYCLES - 1);
  // Periodic correction pulse and scaled amount
  always_ff @(posedge clock) begin
    if (srst) begin
      per_cnt    <= '0;
      trim_apply <= 1'b0;
      trim_ppb   <= 19'sh00000;
    end else begin
      trim_apply <= 1'b0;
      if (per_cnt >= per_last) begin
        per_cnt    <= '0;
        trim_apply <= (trim_step != 7'sh00);
        if (trim[rsa_pkg::TRIM_FINE_BIT]) begin
          trim_ppb <= 19'(19'(trim_step) * rsa_pkg::STEP_PPB_FINE);
        end else begin
          trim_ppb <= 19'(19'(trim_step) * rsa_pkg::STEP_PPB_COARSE);
        end
      end else begin
        per_cnt <= rsa_pkg::PERIOD_W'(per_cnt + 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cmd_count;
    (state == rsa_pkg::ST_CMD) && cs_q2 && sck_rise && bit_cnt != 3'h7 |=> bit_cnt == $past(bit_cnt) + 3'h1;
  endproperty
  a_cmd_count: assert property (p_cmd_count) else $error("command bit not counted on rising edge");
  property p_read_entry;
    (state == rsa_pkg::ST_CMD) && cs_q2 && sck_rise && bit_cnt == 3'h7
      && next_cmd[7:4] == rsa_pkg::CMD_CODE && next_cmd[0] |=> state == rsa_pkg::ST_RD;
  endproperty
  a_read_entry: assert property (p_read_entry) else $error("read state not entered");
  property p_drive_on_fall;
    $rose(serial_data_oe) || $changed(serial_data_out) && serial_data_oe |-> $past(sck_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("data line changed off a falling edge");
  property p_write_entry;
    (state == rsa_pkg::ST_CMD) && cs_q2 && sck_rise && bit_cnt == 3'h7
      && next_cmd[7:4] == rsa_pkg::CMD_CODE && !next_cmd[0] |=> state == rsa_pkg::ST_WR;
  endproperty
  a_write_entry: assert property (p_write_entry) else $error("write state not entered");
  property p_no_access_early;
    (state == rsa_pkg::ST_CMD) && !(sck_rise && bit_cnt == 3'h7) && cs_q2 |=> state == rsa_pkg::ST_CMD;
  endproperty
  a_no_access_early: assert property (p_no_access_early) else $error("left wait before eighth clock");
  property p_status2_write;
    wr_commit && cmd_reg == 3'h1 |=> status2 == $past(next_wr) ##0 status1 == $past(status1);
  endproperty
  a_status2_write: assert property (p_status2_write) else $error("status select bit misrouted");
  property p_alarm_len;
    (state == rsa_pkg::ST_WR) && cmd_reg[2:1] == rsa_pkg::GRP_ALARM && !cmd_reg[0] && !alarm1_mode
      |-> byte_cnt <= 2'h1;
  endproperty
  a_alarm_len: assert property (p_alarm_len) else $error("free byte took more than one byte");
  property p_trim_scale;
    trim_apply && !$past(trim[rsa_pkg::TRIM_FINE_BIT]) |-> trim_ppb == 19'(19'($past(trim_step)) * 19'sh00bec);
  endproperty
  a_trim_scale: assert property (p_trim_scale) else $error("coarse trim scale wrong");
  property p_trim_zero;
    trim_step == 7'sh00 |=> !trim_apply;
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("correction applied with zero count");
  property p_cs_idle;
    !cs_q2 |=> state == rsa_pkg::ST_IDLE ##0 !serial_data_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("transfer not ended by chip select low");

endmodule

/* tb/rsa_host_model.sv */
// Host controller model for the 3-wire serial register port.
// Assumes the bench resolves the shared data line and feeds the level back on line.
`timescale 1ns/10ps
module rsa_host_model (
  input  wire logic clock,
  input  wire logic line,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      host_bit,
  output logic      host_oe
);
  int half;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus: select low, serial clock parked high
  initial begin
    half = 6;
    chip_select = 1'b0;
    serial_clock = 1'b1;
    host_bit = 1'b0;
    host_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame: command MSB first, data LSB first, sampled at each rise
  task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [23:0] wdata,
                      output logic [23:0] rdata);
    int i;
    rdata = 24'h000000;
    @(posedge clock);
    chip_select <= 1'b1;
    repeat (4) @(posedge clock);
    for (i = 0; i < nbits; i++) begin
      serial_clock <= 1'b0;
      host_oe      <= (i < 8) || !cmd[0];
      host_bit     <= (i < 8) ? cmd[7 - i] : wdata[i - 8];
      repeat (half) @(posedge clock);
      if (i >= 8)
        rdata[i - 8] = line;
      serial_clock <= 1'b1;
      repeat (half) @(posedge clock);
    end
    // Frame end releases the line and the select
    chip_select <= 1'b0;
    host_oe     <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the serial register port and clock-rate trim.
// Assumes the host model drives the port; short trim periods are set by parameter.
`timescale 1ns/10ps
module testbench;
  localparam int unsigned CO_CYC = 200;
  localparam int unsigned FI_CYC = 600;
  logic               clock;
  logic               srst;
  logic               cs;
  logic               sclk;
  logic               hbit;
  logic               hoe;
  logic               line;
  logic               last_line = 1'b0;
  logic               sdo;
  logic               soe;
  logic               a1m;
  logic               a2e;
  logic               tapply;
  logic signed [18:0] ppb;
  logic [23:0]        rd;
  logic [7:0]         tv [6] = '{8'hfc, 8'h02, 8'h80, 8'hfe, 8'hfd, 8'h03};
  int                 bad_count;
  int                 compares;
  int                 pulses;
  int                 gap;
  int                 last_pulse;
  int                 cyc;
  int                 oe_cycles;
  int                 p0;
  int                 per;
  int                 n;

  ////////////////////////////////////////////////////////////////////////////
  // Shared data line; undriven it toggles every cycle
  assign line = soe ? sdo : (hoe ? hbit : ~last_line);

  rsa_core #(.COARSE_CYCLES(CO_CYC), .FINE_CYCLES(FI_CYC)) dut_u (
    .clock(clock), .srst(srst), .chip_select(cs), .serial_clock(sclk), .serial_data_in(line),
    .serial_data_out(sdo), .serial_data_oe(soe), .alarm1_mode(a1m), .second_alarm_enable(a2e),
    .trim_apply(tapply), .trim_ppb(ppb));

  rsa_host_model host_u (
    .clock(clock), .line(line), .chip_select(cs), .serial_clock(sclk), .host_bit(hbit), .host_oe(hoe));

  // System clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Pulse spacing, drive activity and floating-line history
  always @(posedge clock) begin
    last_line <= line;
    cyc <= cyc + 1;
    if (tapply === 1'b1) begin
      gap <= cyc - last_pulse;
      last_pulse <= cyc;
      pulses <= pulses + 1;
    end
    if (soe === 1'b1)
      oe_cycles <= oe_cycles + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] cmd(input logic [1:0] grp, input logic sel, input logic rw);
    return {rsa_pkg::CMD_CODE, grp, sel, rw};
  endfunction

  // Signed step field, bit 1 most significant, times the step size
  function automatic int ppb_of(input logic [7:0] v);
    logic [6:0] s;
    s = {v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    return $signed(s) * (v[0] ? 1017 : 3052);
  endfunction

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] grp, input logic sel, input int nb, input logic [23:0] d);
    host_u.xfer(cmd(grp, sel, 1'b0), 8 + 8 * nb, d, rd);
  endtask

  task automatic rdc(input string what, input logic [1:0] grp, input logic sel, input int nb,
                     input logic [23:0] exp);
    host_u.xfer(cmd(grp, sel, 1'b1), 8 + 8 * nb, 24'h000000, rd);
    chk(what, exp, rd);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    $display("BAD watchdog expected end seen timeout");
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    srst = 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    // Reset values of every register
    rdc("status1", 2'h0, 1'b0, 1, 24'h00);
    rdc("status2", 2'h0, 1'b1, 1, 24'h00);
    rdc("alarm1", 2'h2, 1'b0, 1, 24'h00);
    rdc("alarm2", 2'h2, 1'b1, 1, 24'h00);
    rdc("trim", 2'h3, 1'b0, 1, 24'h00);
    rdc("free", 2'h3, 1'b1, 1, 24'h00);
    chk("modes", 24'h0, {22'h0, a1m, a2e});
    // Alarm one in time mode, alarm two as one byte
    wr(2'h0, 1'b1, 1, 24'h02);
    chk("alarm1 mode", 24'h2, {22'h0, a1m, a2e});
    wr(2'h2, 1'b0, 3, 24'h332211);
    rdc("alarm1 time", 2'h2, 1'b0, 3, 24'h332211);
    wr(2'h2, 1'b1, 1, 24'h44);
    rdc("alarm2 byte", 2'h2, 1'b1, 1, 24'h44);
    // Alarm two in time mode, alarm one back to a free byte
    wr(2'h0, 1'b1, 1, 24'h40);
    chk("alarm2 enable", 24'h1, {22'h0, a1m, a2e});
    wr(2'h2, 1'b1, 3, 24'h776655);
    rdc("alarm2 time", 2'h2, 1'b1, 3, 24'h776655);
    rdc("alarm1 free byte", 2'h2, 1'b0, 1, 24'h11);
    wr(2'h3, 1'b1, 1, 24'ha5);
    host_u.half = 20;
    rdc("free slow", 2'h3, 1'b1, 1, 24'ha5);
    host_u.half = 6;
    rdc("status2 back", 2'h0, 1'b1, 1, 24'h40);
    rdc("status1 apart", 2'h0, 1'b0, 1, 24'h00);
    chk("oe idle", 24'h0, {23'h0, soe});
    // Short, aborted and refused frames leave trim alone
    wr(2'h3, 1'b0, 1, 24'h80);
    host_u.xfer(cmd(2'h3, 1'b0, 1'b0), 7, 24'h0, rd);
    host_u.xfer(cmd(2'h3, 1'b0, 1'b0), 12, 24'h0f, rd);
    host_u.xfer({4'h5, 2'h3, 1'b0, 1'b0}, 16, 24'h0f, rd);
    n = oe_cycles;
    host_u.xfer({4'h5, 2'h3, 1'b0, 1'b1}, 16, 24'h0, rd);
    host_u.xfer(cmd(2'h1, 1'b0, 1'b1), 16, 24'h0, rd);
    chk("oe refused", 24'(n), 24'(oe_cycles));
    rdc("trim kept", 2'h3, 1'b0, 1, 24'h80);
    // Trim extremes in both resolutions, unit steps in the coarse one only
    for (int k = 0; k < 6; k++) begin
      wr(2'h3, 1'b0, 1, {16'h0, tv[k]});
      p0 = pulses;
      per = tv[k][0] ? FI_CYC : CO_CYC;
      repeat (3 * per + 20) @(posedge clock);
      chk("trim ppb", {5'h00, 19'(ppb_of(tv[k]))}, {5'h00, ppb});
      chk("trim gap", 24'(per), 24'(gap));
      chk("trim pulses", 24'h1, {23'h0, pulses - p0 > 1});
    end
    // Zero step count applies nothing
    wr(2'h3, 1'b0, 1, 24'h01);
    p0 = pulses;
    repeat (3 * FI_CYC) @(posedge clock);
    chk("zero ppb", 24'h0, {5'h00, ppb});
    chk("zero pulses", 24'(p0), 24'(pulses));
    wr(2'h3, 1'b0, 1, 24'h00);
    rdc("trim cleared", 2'h3, 1'b0, 1, 24'h00);
    end_sim;
  end
endmodule
